// File: commit_pkg.sv
// Constants and types for the parameter commit and write check block
// Operation
// - Mode 0 written parameters wait in pending area
// - Writing zero to commit register triggers commit
// - Nonvolatile commit stores and activates pending data
// - Working memory commit activates only, store untouched
// - Reading a commit register gives register error
// - Reference and broadcast data act without commit
// - Mode 0 activates on commit, 1 immediately
// - Mode 0 related limits, 1 fixed limits
// - Mode 1 write sets related parameter defaults
// - Mode 0 saves valid words, 1 all-or-nothing
// - Unsupported function code gives function error
// - Nonexistent register gives register number error; a read checks its start register only
// - Broadcast must start at command or reference
// - Zero count or byte count not twice the count gives bit error
// - Out of range or contradictory data errors
// - Read-only or run-locked write gives mode error
// - Nonvolatile fault allows only permitted parameters
// - Undervoltage fault rejects every write, commit too
// - Write during parameter processing gives busy error
// - Broadcast carries address zero, no reply
package commit_pkg;
	localparam logic [7:0]  FC_READ       = 8'h03;
	localparam logic [7:0]  FC_LOOP       = 8'h08;
	localparam logic [7:0]  FC_WRITE      = 8'h10;
	localparam logic [7:0]  ERR_NONE      = 8'h00;
	localparam logic [7:0]  ERR_FUNC      = 8'h01;
	localparam logic [7:0]  ERR_REG       = 8'h02;
	localparam logic [7:0]  ERR_BITS      = 8'h03;
	localparam logic [7:0]  ERR_DATA      = 8'h21;
	localparam logic [7:0]  ERR_WMODE     = 8'h22;
	localparam logic [7:0]  ERR_UV        = 8'h23;
	localparam logic [7:0]  ERR_BUSY      = 8'h24;
	localparam logic [15:0] OFS_CMD       = 16'h0001;
	localparam logic [15:0] OFS_FREF      = 16'h0002;
	localparam logic [15:0] OFS_MON_LO    = 16'h0020;
	localparam logic [15:0] OFS_MON_HI    = 16'h003F;
	localparam logic [15:0] OFS_PARAM     = 16'h0400;
	localparam logic [15:0] OFS_MODE      = 16'h043C;
	localparam logic [15:0] OFS_COMMIT_NV = 16'h0900;
	localparam logic [15:0] OFS_COMMIT_WM = 16'h0910;
	localparam int          PARAM_N       = 32;
	localparam logic        MODE_RESET    = 1'b1;
	localparam logic [15:0] PARAM_RESET   = 16'h0000;
	localparam logic [15:0] LIM_LO        = 16'h0000;
	localparam logic [15:0] LIM_HI_A      = 16'h0FFF;
	localparam logic [15:0] LIM_HI_B      = 16'h00FF;
	localparam int          LIM_SPLIT     = 16;
	localparam logic [31:0] RUN_LOCK_MASK = 32'h000000F0;
	localparam logic [31:0] PERMIT_MASK   = 32'h00000007;
	localparam int          CLK_NS        = 10;
	localparam int          NV_WORD_NS    = 1000;
	localparam int          NV_WORD_CYC   = (NV_WORD_NS + CLK_NS - 1) / CLK_NS;
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_WRITE = 4'b0010,
		ST_APPLY = 4'b0100,
		ST_READ  = 4'b1000
	} state_t;
endpackage

// File: limit_check.sv
// Range check of one parameter word
`timescale 1ns/100ps
module limit_check #(
	parameter int IW = 5
) (
	input  wire logic [IW-1:0] idx_in,
	input  wire logic [15:0]   value_in,
	input  wire logic          fixed_in,
	input  wire logic [15:0]   rel_in,
	output logic               ok_out
);
	logic [15:0] hi;
	logic        in_fix;
	logic        rel_ok;

	assign hi     = (int'(idx_in) < commit_pkg::LIM_SPLIT) ? commit_pkg::LIM_HI_A
		: commit_pkg::LIM_HI_B;
	assign in_fix = (value_in >= commit_pkg::LIM_LO) && (value_in <= hi);
	// Even index is lower bound of its pair, odd is upper
	assign rel_ok = idx_in[0] ? (value_in >= rel_in) : (value_in <= rel_in);
	assign ok_out = fixed_in ? in_fix : (in_fix && rel_ok);
endmodule

// File: master_model.sv
// Modbus master model that issues requests and collects the replies
`timescale 1ns/100ps
module master_model (
	input  wire logic        mclk_in,
	input  wire logic        rsp_valid_in,
	input  wire logic        rsp_exc_in,
	input  wire logic        rsp_last_in,
	input  wire logic [7:0]  rsp_code_in,
	input  wire logic [15:0] rsp_data_in,
	output logic             req_valid_out,
	output logic [7:0]       req_func_out,
	output logic             req_bcast_out,
	output logic [15:0]      req_addr_out,
	output logic [7:0]       req_count_out,
	output logic [7:0]       req_bytes_out,
	output logic             data_valid_out,
	output logic [15:0]      data_out
);
	int          rsp_n = 0;
	logic        rsp_done = 1'b0;
	logic        rsp_exc_q;
	logic [7:0]  rsp_code_q;
	logic [15:0] rsp_data_q;

	initial begin
		req_valid_out = 1'b0;
		req_func_out = 8'h00;
		req_bcast_out = 1'b0;
		req_addr_out = 16'h0000;
		req_count_out = 8'h00;
		req_bytes_out = 8'h00;
		data_valid_out = 1'b0;
		data_out = 16'h0000;
	end

	// Reply capture
	always @(posedge mclk_in) begin
		if (req_valid_out === 1'b1) begin
			rsp_n <= 0;
			rsp_done <= 1'b0;
		end else if (rsp_valid_in === 1'b1) begin
			rsp_n <= rsp_n + 1;
			rsp_exc_q <= rsp_exc_in;
			rsp_code_q <= rsp_code_in;
			rsp_data_q <= rsp_data_in;
			if (rsp_last_in === 1'b1) begin
				rsp_done <= 1'b1;
			end
		end
	end

	// One request frame, entered just after a rising edge
	task automatic send(input logic [7:0] f, input logic b, input logic [15:0] a,
		input logic [7:0] n, input logic [7:0] nb, input logic [15:0] w [4]);
		int i;
		req_valid_out = 1'b1;
		req_func_out = f;
		req_bcast_out = b;
		req_addr_out = a;
		req_count_out = n;
		req_bytes_out = nb;
		@(posedge mclk_in);
		#1;
		req_valid_out = 1'b0;
		req_bcast_out = 1'b0;
		req_func_out = ~f;
		req_addr_out = ~a;
		req_count_out = ~n;
		req_bytes_out = ~nb;
		// Exactly count words follow a write header, back to back
		for (i = 0; i < ((f == commit_pkg::FC_WRITE) ? int'(n) : 0); i++) begin
			data_valid_out = 1'b1;
			data_out = w[i % 4];
			@(posedge mclk_in);
			#1;
		end
		data_valid_out = 1'b0;
		data_out = ~data_out;
		// Broadcast waits out the full window, expecting silence
		for (i = 0; i < 40 && (b || !rsp_done); i++) begin
			@(posedge mclk_in);
			#1;
		end
	endtask
endmodule

// File: nv_sweep.sv
// Sweep of all working values into nonvolatile storage
`timescale 1ns/100ps
module nv_sweep #(
	parameter int N   = 32,
	parameter int CYC = 100,
	parameter int AW  = 5
) (
	input  wire logic          mclk_in,
	input  wire logic          rst_in,
	input  wire logic          start_in,
	input  wire logic [15:0]   word_in,
	output logic               busy_out,
	output logic               we_out,
	output logic [AW-1:0]      addr_out,
	output logic [15:0]        data_out
);
	logic [15:0] cnt_q;
	logic        slot_end;

	assign slot_end = (cnt_q == 16'(CYC - 1));

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			busy_out <= 1'b0;
			we_out   <= 1'b0;
			addr_out <= '0;
			data_out <= 16'h0000;
			cnt_q    <= 16'h0000;
		end else begin
			we_out <= busy_out && slot_end;
			if (start_in && !busy_out) begin
				busy_out <= 1'b1;
				addr_out <= '0;
				cnt_q    <= 16'h0000;
			end else if (busy_out && slot_end) begin
				data_out <= word_in;
				cnt_q    <= 16'h0000;
				busy_out <= (addr_out != AW'(N - 1));
			end else if (busy_out) begin
				cnt_q <= cnt_q + 16'h0001;
			end
			if (we_out && busy_out)
				addr_out <= addr_out + AW'(1);
		end
	end
endmodule

// File: param_commit.sv
// Modbus parameter commit, write checking and error reply logic
`timescale 1ns/100ps
module param_commit #(
	parameter int PARAM_N = commit_pkg::PARAM_N,
	parameter int NV_CYC  = commit_pkg::NV_WORD_CYC
) (
	input  wire logic          mclk_in,
	input  wire logic          rst_in,
	input  wire logic          req_valid_in,
	input  wire logic [7:0]    req_func_in,
	input  wire logic          req_bcast_in,
	input  wire logic [15:0]   req_addr_in,
	input  wire logic [7:0]    req_count_in,
	input  wire logic [7:0]    req_bytes_in,
	input  wire logic          data_valid_in,
	input  wire logic [15:0]   data_in,
	input  wire logic          run_in,
	input  wire logic          dc_bus_undervoltage_fault_in,
	input  wire logic          nonvolatile_data_fault_in,
	input  wire logic [4:0]    act_idx_in,
	output logic               rsp_valid_out,
	output logic               rsp_exc_out,
	output logic               rsp_last_out,
	output logic [7:0]         rsp_code_out,
	output logic [15:0]        rsp_data_out,
	output logic [15:0]        cmd_word_out,
	output logic [15:0]        freq_ref_out,
	output logic               enter_mode_out,
	output logic [15:0]        act_data_out,
	output logic               busy_out,
	output logic               nv_we_out,
	output logic [4:0]         nv_addr_out,
	output logic [15:0]        nv_data_out
);
	localparam int IW = 5;
	localparam logic [15:0] PAR_LAST = commit_pkg::OFS_PARAM + 16'(PARAM_N - 1);

	function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo,
		input logic [15:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction

	commit_pkg::state_t state_q;
	commit_pkg::state_t state_d;
	logic [15:0]   pend_q [PARAM_N];
	logic [15:0]   act_q [PARAM_N];
	logic [15:0]   stage_q [PARAM_N];
	logic [PARAM_N-1:0] staged_q;
	logic [15:0]   addr_q;
	logic [7:0]    left_q;
	logic [7:0]    cnt_q;
	logic [7:0]    func_q;
	logic [7:0]    err_q;
	logic          rej_q;
	logic          bc_q;
	logic          fm_q;
	logic          cnv_q;
	logic          cwm_q;
	logic [7:0]    hdr_err;
	logic [7:0]    w_err;
	logic [15:0]   rd_word;

	wire [15:0] ha = req_addr_in;
	wire f_rd = (req_func_in == commit_pkg::FC_READ);
	wire f_lp = (req_func_in == commit_pkg::FC_LOOP);
	wire f_wr = (req_func_in == commit_pkg::FC_WRITE);
	wire h_ref = in_rng(ha, commit_pkg::OFS_CMD, commit_pkg::OFS_FREF);
	wire h_mon = in_rng(ha, commit_pkg::OFS_MON_LO, commit_pkg::OFS_MON_HI);
	wire h_par = in_rng(ha, commit_pkg::OFS_PARAM, PAR_LAST);
	wire h_mode = (ha == commit_pkg::OFS_MODE);
	wire h_cmt = (ha == commit_pkg::OFS_COMMIT_NV) || (ha == commit_pkg::OFS_COMMIT_WM);
	wire h_exr = h_ref || h_mon || h_par || h_mode;
	wire h_exw = h_exr || h_cmt;
	wire bytes_ok = (req_count_in != 8'h00) &&
		({1'b0, req_bytes_in} == {req_count_in, 1'b0});
	wire st_idle = (state_q == commit_pkg::ST_IDLE);
	wire st_write = (state_q == commit_pkg::ST_WRITE);
	wire st_apply = (state_q == commit_pkg::ST_APPLY);
	wire st_read = (state_q == commit_pkg::ST_READ);
	wire take = st_idle && req_valid_in;
	wire go_write = take && f_wr;
	wire go_read = take && f_rd && !req_bcast_in && (hdr_err == commit_pkg::ERR_NONE);
	wire quick = take && !req_bcast_in && !f_wr && !go_read;

	wire w_ref = in_rng(addr_q, commit_pkg::OFS_CMD, commit_pkg::OFS_FREF);
	wire w_mon = in_rng(addr_q, commit_pkg::OFS_MON_LO, commit_pkg::OFS_MON_HI);
	wire w_par = in_rng(addr_q, commit_pkg::OFS_PARAM, PAR_LAST);
	wire w_mode = (addr_q == commit_pkg::OFS_MODE);
	wire w_cnv = (addr_q == commit_pkg::OFS_COMMIT_NV);
	wire w_cwm = (addr_q == commit_pkg::OFS_COMMIT_WM);
	wire [IW-1:0] wi = IW'(addr_q - commit_pkg::OFS_PARAM);
	wire w_take = st_write && data_valid_in;
	wire w_ok = w_take && !rej_q && (w_err == commit_pkg::ERR_NONE);
	wire apply_ok = (err_q == commit_pkg::ERR_NONE);
	wire nv_start = st_apply && apply_ok && cnv_q;
	wire lim_ok;

	limit_check #(
		.IW(IW)
	) u_limit (
		.idx_in  (wi),
		.value_in(data_in),
		.fixed_in(fm_q),
		.rel_in  (pend_q[wi ^ IW'(1)]),
		.ok_out  (lim_ok)
	);

	nv_sweep #(
		.N  (PARAM_N),
		.CYC(NV_CYC),
		.AW (IW)
	) u_nv (
		.mclk_in (mclk_in),
		.rst_in  (rst_in),
		.start_in(nv_start),
		.word_in (act_q[nv_addr_out]),
		.busy_out(busy_out),
		.we_out  (nv_we_out),
		.addr_out(nv_addr_out),
		.data_out(nv_data_out)
	);

	// Header checks in priority order
	always_comb begin
		hdr_err = commit_pkg::ERR_NONE;
		if (!(f_rd || f_lp || f_wr))
			hdr_err = commit_pkg::ERR_FUNC;
		else if (req_bcast_in && f_wr && !h_ref)
			hdr_err = commit_pkg::ERR_REG;
		else if (f_rd && !h_exr)
			hdr_err = commit_pkg::ERR_REG;
		else if (f_wr && !h_exw)
			hdr_err = commit_pkg::ERR_REG;
		else if ((f_rd && req_count_in == 8'h00) || (f_wr && !bytes_ok))
			hdr_err = commit_pkg::ERR_BITS;
		else if (f_wr && dc_bus_undervoltage_fault_in)
			hdr_err = commit_pkg::ERR_UV;
		else if (f_wr && busy_out)
			hdr_err = commit_pkg::ERR_BUSY;
	end

	// Per word checks
	always_comb begin
		w_err = commit_pkg::ERR_NONE;
		if (w_mon)
			w_err = commit_pkg::ERR_WMODE;
		else if (w_par && nonvolatile_data_fault_in && !commit_pkg::PERMIT_MASK[wi])
			w_err = commit_pkg::ERR_WMODE;
		else if (w_par && run_in && commit_pkg::RUN_LOCK_MASK[wi])
			w_err = commit_pkg::ERR_WMODE;
		else if (w_par && !lim_ok)
			w_err = commit_pkg::ERR_DATA;
		else if (w_mode && nonvolatile_data_fault_in)
			w_err = commit_pkg::ERR_WMODE;
		else if (w_mode && data_in > 16'h0001)
			w_err = commit_pkg::ERR_DATA;
		else if ((w_cnv || w_cwm) && data_in != 16'h0000)
			w_err = commit_pkg::ERR_DATA;
		else if (!(w_ref || w_par || w_mode || w_cnv || w_cwm))
			w_err = commit_pkg::ERR_REG;
	end

	assign rd_word = w_ref ? ((addr_q == commit_pkg::OFS_CMD) ? cmd_word_out : freq_ref_out)
		: w_par ? pend_q[wi]
		: w_mode ? {15'h0000, enter_mode_out}
		: 16'h0000;

	always_comb begin
		state_d = state_q;
		case (state_q)
			commit_pkg::ST_IDLE: begin
				if (go_write)
					state_d = (req_count_in == 8'h00) ? commit_pkg::ST_APPLY
						: commit_pkg::ST_WRITE;
				else if (go_read)
					state_d = commit_pkg::ST_READ;
			end
			commit_pkg::ST_WRITE: begin
				if (w_take && left_q == 8'h01)
					state_d = commit_pkg::ST_APPLY;
			end
			commit_pkg::ST_APPLY: state_d = commit_pkg::ST_IDLE;
			commit_pkg::ST_READ: begin
				if (left_q == 8'h01)
					state_d = commit_pkg::ST_IDLE;
			end
			default: state_d = commit_pkg::ST_IDLE;
		endcase
	end

	// Pending, staged and working parameter arrays
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			for (int i = 0; i < PARAM_N; i++) begin
				pend_q[i]  <= commit_pkg::PARAM_RESET;
				act_q[i]   <= commit_pkg::PARAM_RESET;
				stage_q[i] <= commit_pkg::PARAM_RESET;
			end
			staged_q <= '0;
		end else if (w_ok && w_par && !fm_q) begin
			pend_q[wi] <= data_in;
		end else if (w_ok && w_par) begin
			stage_q[wi]  <= data_in;
			staged_q[wi] <= 1'b1;
		end else if (st_apply) begin
			for (int i = 0; i < PARAM_N; i++) begin
				if (apply_ok && fm_q && staged_q[i]) begin
					pend_q[i] <= stage_q[i];
					act_q[i]  <= stage_q[i];
				end else if (apply_ok && fm_q && staged_q[i ^ 1]) begin
					pend_q[i] <= stage_q[i ^ 1];
					act_q[i]  <= stage_q[i ^ 1];
				end else if (apply_ok && (cnv_q || cwm_q)) begin
					act_q[i] <= pend_q[i];
				end
			end
			staged_q <= '0;
		end
	end

	// Frame control and immediate registers
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			state_q        <= commit_pkg::ST_IDLE;
			addr_q         <= 16'h0000;
			left_q         <= 8'h00;
			cnt_q          <= 8'h00;
			func_q         <= 8'h00;
			err_q          <= commit_pkg::ERR_NONE;
			rej_q          <= 1'b0;
			bc_q           <= 1'b0;
			fm_q           <= commit_pkg::MODE_RESET;
			cnv_q          <= 1'b0;
			cwm_q          <= 1'b0;
			enter_mode_out <= commit_pkg::MODE_RESET;
			cmd_word_out   <= 16'h0000;
			freq_ref_out   <= 16'h0000;
		end else begin
			state_q <= state_d;
			if (take) begin
				addr_q <= req_addr_in;
				left_q <= req_count_in;
				cnt_q  <= req_count_in;
				func_q <= req_func_in;
				bc_q   <= req_bcast_in;
				fm_q   <= enter_mode_out;
				err_q  <= hdr_err;
				rej_q  <= (hdr_err != commit_pkg::ERR_NONE);
			end else if (w_take || st_read) begin
				addr_q <= addr_q + 16'h0001;
				left_q <= left_q - 8'h01;
			end
			if (w_take && !rej_q && apply_ok && w_err != commit_pkg::ERR_NONE)
				err_q <= w_err;
			if (w_ok && w_mode)
				enter_mode_out <= data_in[0];
			if (w_ok && w_ref && addr_q == commit_pkg::OFS_CMD)
				cmd_word_out <= data_in;
			if (w_ok && w_ref && addr_q == commit_pkg::OFS_FREF)
				freq_ref_out <= data_in;
			if (st_apply) begin
				cnv_q <= 1'b0;
				cwm_q <= 1'b0;
			end else begin
				cnv_q <= cnv_q || (w_ok && w_cnv);
				cwm_q <= cwm_q || (w_ok && w_cwm);
			end
		end
	end

	// Replies
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			rsp_valid_out <= 1'b0;
			rsp_exc_out   <= 1'b0;
			rsp_last_out  <= 1'b0;
			rsp_code_out  <= 8'h00;
			rsp_data_out  <= 16'h0000;
			act_data_out  <= 16'h0000;
		end else begin
			act_data_out  <= act_q[act_idx_in];
			rsp_valid_out <= quick || st_read || (st_apply && !bc_q);
			if (quick) begin
				rsp_exc_out  <= (hdr_err != commit_pkg::ERR_NONE);
				rsp_code_out <= (hdr_err != commit_pkg::ERR_NONE) ? hdr_err : req_func_in;
				rsp_data_out <= f_lp ? req_addr_in : 16'h0000;
				rsp_last_out <= 1'b1;
			end else if (st_read) begin
				rsp_exc_out  <= 1'b0;
				rsp_code_out <= func_q;
				rsp_data_out <= rd_word;
				rsp_last_out <= (left_q == 8'h01);
			end else if (st_apply) begin
				rsp_exc_out  <= !apply_ok;
				rsp_code_out <= apply_ok ? func_q : err_q;
				rsp_data_out <= {8'h00, cnt_q};
				rsp_last_out <= 1'b1;
			end
		end
	end

	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (rst_in);

	sequence s_take_bad_func;
		take && !req_bcast_in && !(f_rd || f_lp || f_wr);
	endsequence
	sequence s_nv_commit;
		st_apply && apply_ok && cnv_q && !busy_out;
	endsequence

	a_bad_func_reply: assert property (s_take_bad_func |=> rsp_valid_out && rsp_exc_out
		&& rsp_code_out == commit_pkg::ERR_FUNC)
		else $error("unsupported function not rejected");
	a_read_commit_reg: assert property (take && !req_bcast_in && f_rd
		&& req_addr_in == commit_pkg::OFS_COMMIT_NV
		|=> rsp_exc_out && rsp_code_out == commit_pkg::ERR_REG)
		else $error("commit register read not rejected");
	a_nv_commit_run: assert property (s_nv_commit |=> busy_out ##[1:400] nv_we_out)
		else $error("nonvolatile commit did not start");
	a_wm_commit_copy: assert property (st_apply && apply_ok && cwm_q && !fm_q
		|=> act_q[0] == $past(pend_q[0]) && !(busy_out && !$past(busy_out)))
		else $error("working memory commit wrong");
	a_mode0_no_act: assert property (st_write && !fm_q |=> $stable(act_q[0]))
		else $error("mode 0 write changed working value");
	a_mode1_atomic: assert property (st_apply && fm_q && !apply_ok
		|=> $stable(pend_q[0]) && $stable(act_q[0]))
		else $error("mode 1 failed frame changed data");
	a_uv_reject: assert property (take && f_wr && h_ref && bytes_ok
		&& dc_bus_undervoltage_fault_in |=> rej_q && err_q == commit_pkg::ERR_UV)
		else $error("undervoltage write not rejected");
	a_busy_reject: assert property (take && f_wr && h_ref && bytes_ok && busy_out
		&& !dc_bus_undervoltage_fault_in |=> err_q == commit_pkg::ERR_BUSY)
		else $error("busy write not rejected");
	a_reject_hold: assert property (st_write && rej_q
		|=> $stable(cmd_word_out) && $stable(freq_ref_out) && $stable(enter_mode_out))
		else $error("rejected frame changed state");
	a_bcast_silent: assert property (st_apply && bc_q |=> !rsp_valid_out)
		else $error("broadcast produced a reply");
endmodule

// File: tb.sv
// Self-checking testbench for the parameter commit and write check block
`timescale 1ns/100ps
module tb;
	logic        mclk_in, rst_in, run_in, data_valid_in, req_valid_in, req_bcast_in;
	logic        dc_bus_undervoltage_fault_in, nonvolatile_data_fault_in;
	logic [4:0]  act_idx_in, nv_addr_out;
	logic [7:0]  req_func_in, req_count_in, req_bytes_in, rsp_code_out, f;
	logic [15:0] req_addr_in, data_in, rsp_data_out, cmd_word_out, freq_ref_out;
	logic [15:0] act_data_out, nv_data_out, v, c;
	logic        rsp_valid_out, rsp_exc_out, rsp_last_out, enter_mode_out, busy_out, nv_we_out;
	logic [15:0] nv_mem [32];
	int          fail_count, check_count, cyc, nv_cnt, seed, i;

	param_commit #(.NV_CYC(2)) dut (.mclk_in, .rst_in, .req_valid_in, .req_func_in,
		.req_bcast_in, .req_addr_in, .req_count_in, .req_bytes_in, .data_valid_in, .data_in,
		.run_in, .dc_bus_undervoltage_fault_in, .nonvolatile_data_fault_in, .act_idx_in,
		.rsp_valid_out, .rsp_exc_out, .rsp_last_out, .rsp_code_out, .rsp_data_out,
		.cmd_word_out, .freq_ref_out, .enter_mode_out, .act_data_out, .busy_out,
		.nv_we_out, .nv_addr_out, .nv_data_out);

	master_model m (.mclk_in(mclk_in), .rsp_valid_in(rsp_valid_out),
		.rsp_exc_in(rsp_exc_out), .rsp_last_in(rsp_last_out), .rsp_code_in(rsp_code_out),
		.rsp_data_in(rsp_data_out), .req_valid_out(req_valid_in), .req_func_out(req_func_in),
		.req_bcast_out(req_bcast_in), .req_addr_out(req_addr_in),
		.req_count_out(req_count_in), .req_bytes_out(req_bytes_in),
		.data_valid_out(data_valid_in), .data_out(data_in));

	always #5 mclk_in = ~mclk_in;

	function automatic logic [7:0] exp_code(input logic [7:0] fc, input logic [7:0] e);
		return (e == commit_pkg::ERR_NONE) ? fc : e;
	endfunction

	function automatic logic [15:0] lim_hi(input int idx);
		return (idx < commit_pkg::LIM_SPLIT) ? commit_pkg::LIM_HI_A : commit_pkg::LIM_HI_B;
	endfunction

	task automatic finish_test();
		if (fail_count == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic rq(input logic [7:0] fc, input logic [15:0] a, input logic [7:0] n,
		input logic [7:0] nb, input logic [15:0] w0, input logic [15:0] w1, input logic [7:0] e);
		m.send(fc, 1'b0, a, n, nb, '{w0, w1, w0, w1});
		check(16'(m.rsp_done), 16'h0001);
		check(m.rsp_exc_q, e != commit_pkg::ERR_NONE);
		check(m.rsp_code_q, exp_code(fc, e));
		if (e == commit_pkg::ERR_NONE && fc == commit_pkg::FC_WRITE) begin
			check(m.rsp_data_q, n);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] n, input logic [15:0] w0,
		input logic [15:0] w1, input logic [7:0] e);
		rq(commit_pkg::FC_WRITE, a, n, 8'(2 * n), w0, w1, e);
	endtask

	task automatic chk_act(input logic [4:0] idx, input logic [15:0] exp);
		act_idx_in = idx;
		repeat (2) @(posedge mclk_in);
		#1;
		check(act_data_out, exp);
	endtask

	// Cycle ceiling and capture of stored words
	always @(posedge mclk_in) begin
		cyc <= cyc + 1;
		if (nv_we_out === 1'b1) begin
			nv_cnt <= nv_cnt + 1;
			nv_mem[nv_addr_out] <= nv_data_out;
		end
		if (cyc == 6000) begin
			fail_count++;
			finish_test();
		end
	end

	initial begin
		seed = 32'hA174;
		mclk_in = 1'b0;
		rst_in = 1'b1;
		run_in = 1'b0;
		dc_bus_undervoltage_fault_in = 1'b0;
		nonvolatile_data_fault_in = 1'b0;
		act_idx_in = 5'h00;
		repeat (20) @(posedge mclk_in);
		#1;
		rst_in = 1'b0;
		@(posedge mclk_in);
		#1;
		check(enter_mode_out, commit_pkg::MODE_RESET);
		check(busy_out, 16'h0000);
		for (i = 0; i < 8; i++) begin
			f = (i == 0) ? 8'h01 : (i == 1) ? 8'h06 : 8'($random(seed));
			if (f == commit_pkg::FC_READ || f == commit_pkg::FC_LOOP || f == commit_pkg::FC_WRITE) begin
				f = f ^ 8'h80;
			end
			rq(f, 16'h0400, 8'h01, 8'h02, 16'h0000, 16'h0000, commit_pkg::ERR_FUNC);
		end
		c = 16'($random(seed));
		rq(commit_pkg::FC_LOOP, c, 8'h00, 8'h00, 16'h0000, 16'h0000, commit_pkg::ERR_NONE);
		check(m.rsp_data_q, c);
		rq(commit_pkg::FC_READ, 16'h0900, 8'h01, 8'h00, 16'h0, 16'h0, commit_pkg::ERR_REG);
		rq(commit_pkg::FC_READ, 16'h0910, 8'h01, 8'h00, 16'h0, 16'h0, commit_pkg::ERR_REG);
		rq(commit_pkg::FC_READ, 16'h0500, 8'h01, 8'h00, 16'h0, 16'h0, commit_pkg::ERR_REG);
		wr(16'h0500, 8'h01, 16'h0000, 16'h0000, commit_pkg::ERR_REG);
		rq(commit_pkg::FC_READ, 16'h0400, 8'h00, 8'h00, 16'h0, 16'h0, commit_pkg::ERR_BITS);
		rq(commit_pkg::FC_WRITE, 16'h0400, 8'h01, 8'h03, 16'h0, 16'h0, commit_pkg::ERR_BITS);
		wr(16'h043C, 8'h01, 16'h0000, 16'h0000, commit_pkg::ERR_NONE);
		check(enter_mode_out, 16'h0000);
		wr(16'h043C, 8'h01, 16'h0002, 16'h0000, commit_pkg::ERR_DATA);
		wr(16'h0910, 8'h01, 16'h0005, 16'h0000, commit_pkg::ERR_DATA);
		v = 16'($random(seed)) & lim_hi(1);
		wr(16'h0401, 8'h01, v, 16'h0000, commit_pkg::ERR_NONE);
		chk_act(5'd1, 16'h0000);
		wr(16'h0910, 8'h01, 16'h0000, 16'h0000, commit_pkg::ERR_NONE);
		chk_act(5'd1, v);
		check(busy_out, 16'h0000);
		c = (16'($random(seed)) & lim_hi(3)) | 16'h0001;
		wr(16'h0403, 8'h02, c, 16'h0001, commit_pkg::ERR_DATA);
		wr(16'h0910, 8'h01, 16'h0000, 16'h0000, commit_pkg::ERR_NONE);
		chk_act(5'd3, c);
		chk_act(5'd4, 16'h0000);
		wr(16'h043C, 8'h01, 16'h0001, 16'h0000, commit_pkg::ERR_NONE);
		check(enter_mode_out, 16'h0001);
		wr(16'h040F, 8'h02, lim_hi(15), lim_hi(16) + 16'h1, commit_pkg::ERR_DATA);
		chk_act(5'd15, 16'h0000);
		wr(16'h0400, 8'h01, lim_hi(0), 16'h0000, commit_pkg::ERR_NONE);
		chk_act(5'd0, lim_hi(0));
		chk_act(5'd1, lim_hi(0));
		c = 16'($random(seed));
		m.send(commit_pkg::FC_WRITE, 1'b1, commit_pkg::OFS_CMD, 8'h01, 8'h02, '{c, c, c, c});
		check(16'(m.rsp_n), 16'h0000);
		check(cmd_word_out, c);
		m.send(commit_pkg::FC_WRITE, 1'b1, commit_pkg::OFS_FREF, 8'h01, 8'h02, '{~c, c, c, c});
		check(freq_ref_out, ~c);
		m.send(commit_pkg::FC_WRITE, 1'b1, 16'h0003, 8'h01, 8'h02, '{~c, c, c, c});
		check(cmd_word_out, c);
		run_in = 1'b1;
		wr(16'h0405, 8'h01, 16'h0000, 16'h0000, commit_pkg::ERR_WMODE);
		run_in = 1'b0; // Cause removed before going on
		wr(16'h0020, 8'h01, 16'h0000, 16'h0000, commit_pkg::ERR_WMODE);
		nonvolatile_data_fault_in = 1'b1;
		wr(16'h0408, 8'h01, 16'h0001, 16'h0000, commit_pkg::ERR_WMODE);
		wr(16'h0402, 8'h01, 16'h0007, 16'h0000, commit_pkg::ERR_NONE);
		chk_act(5'd2, 16'h0007);
		nonvolatile_data_fault_in = 1'b0;
		dc_bus_undervoltage_fault_in = 1'b1;
		wr(16'h0910, 8'h01, 16'h0000, 16'h0000, commit_pkg::ERR_UV);
		wr(16'h0401, 8'h01, 16'h0001, 16'h0000, commit_pkg::ERR_UV);
		wr(16'h0002, 8'h01, 16'h1234, 16'h0000, commit_pkg::ERR_UV);
		check(freq_ref_out, ~c);
		dc_bus_undervoltage_fault_in = 1'b0;
		// Single nonvolatile commit in the whole run
		wr(16'h0900, 8'h01, 16'h0000, 16'h0000, commit_pkg::ERR_NONE);
		check(busy_out, 16'h0001);
		wr(16'h0402, 8'h01, 16'h0003, 16'h0000, commit_pkg::ERR_BUSY);
		wr(16'h0001, 8'h01, ~c, 16'h0000, commit_pkg::ERR_BUSY);
		check(cmd_word_out, c);
		for (i = 0; i < 400 && busy_out !== 1'b0; i++) begin
			@(posedge mclk_in);
			#1;
		end
		@(posedge mclk_in);
		#1;
		check(16'(nv_cnt), 16'(commit_pkg::PARAM_N));
		check(nv_mem[0], lim_hi(0));
		check(nv_mem[2], 16'h0007);
		chk_act(5'd2, 16'h0007);
		rq(commit_pkg::FC_READ, 16'h0402, 8'h02, 8'h00, 16'h0, 16'h0, commit_pkg::ERR_NONE);
		check(m.rsp_data_q, 16'h0007);
		rq(commit_pkg::FC_READ, 16'h043C, 8'h01, 8'h00, 16'h0, 16'h0, commit_pkg::ERR_NONE);
		check(m.rsp_data_q, 16'h0001);
		finish_test();
	end
endmodule
